// File: shared/acf_pkg.sv
/*
 * acf_pkg: register offsets, field positions, reset values and decode
 * constants for the amplifier channel, analog and fault register bank.
 * assumes: byte-wide control port registers, one clock domain.
 */
package acf_pkg;

    // ========================================================
    // register offsets (byte addresses on the control port)
    localparam logic [7:0] ACF_OFF_RIGHT_VOL   = 8'h05;
    localparam logic [7:0] ACF_OFF_ANALOG_CTRL = 8'h06;
    localparam logic [7:0] ACF_OFF_RESERVED    = 8'h07;
    localparam logic [7:0] ACF_OFF_FAULT       = 8'h08;

    // ========================================================
    // reset values
    localparam logic [7:0] ACF_RST_RIGHT_VOL   = 8'hcf;
    localparam logic [7:0] ACF_RST_ANALOG_CTRL = 8'h51;
    localparam logic [1:0] ACF_RST_TRIP_LEVEL  = 2'h0;

    // ========================================================
    // analog control field positions
    localparam int ACF_BIT_MONO_MODE   = 7;
    localparam int ACF_BIT_RATE_HI     = 6;
    localparam int ACF_BIT_RATE_LO     = 4;
    localparam int ACF_BIT_GAIN_HI     = 3;
    localparam int ACF_BIT_GAIN_LO     = 2;
    localparam int ACF_BIT_MONO_SOURCE = 1;
    localparam int ACF_BIT_ANALOG_RSVD = 0;

    // ========================================================
    // fault register field positions
    localparam int ACF_BIT_TRIP_HI   = 5;
    localparam int ACF_BIT_TRIP_LO   = 4;
    localparam int ACF_BIT_CLK_ERR   = 3;
    localparam int ACF_BIT_OVERCUR   = 2;
    localparam int ACF_BIT_DC_OFFSET = 1;
    localparam int ACF_BIT_OVERTEMP  = 0;

    // ========================================================
    // volume decode
    localparam logic [7:0] ACF_VOL_MUTE_FLOOR = 8'h07;

    // analog gain codes, hundredths of a dBV
    localparam logic [1:0] ACF_GAIN_RESERVED = 2'h3;

    typedef enum logic [2:0] {
        ACF_MODE_STEREO = 3'b001,
        ACF_MODE_MONO_R = 3'b010,
        ACF_MODE_MONO_L = 3'b100
    } acf_mode_type;

endpackage : acf_pkg

// File: rtl/acf_fault_latch.sv
/*
 * acf_fault_latch: fault status flags and overcurrent trip scaling.
 * assumes: raw detector levels synchronous to REF_CLK, shutdown
 * input already synchronous; clock enable gates all state.
 */
`timescale 1ns/1ps
module acf_fault_latch
    import acf_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    input  wire logic       shutdown_n,
    input  wire logic       clk_err_raw,
    input  wire logic       overcur_raw,
    input  wire logic       dc_offset_raw,
    input  wire logic       overtemp_raw,
    input  wire logic [1:0] trip_level,
    output logic      [3:0] flags,
    output logic      [7:0] trip_percent,
    output logic            fault_hold
);

    // ========================================================
    // latch state
    logic [2:0] latched_reg;
    logic [2:0] latched_next;
    logic       sd_reg;
    logic       sd_next;
    logic       clk_err_reg;
    logic       clk_err_next;
    logic       toggle;

    always_comb begin
        sd_next      = shutdown_n;
        toggle       = sd_reg != shutdown_n;
        clk_err_next = clk_err_raw;
        latched_next = latched_reg;
        // shutdown toggle clears; a fresh event in that cycle wins
        if (toggle) begin
            latched_next = 3'h0;
        end
        latched_next = latched_next |
            {overcur_raw, dc_offset_raw, overtemp_raw};
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            latched_reg <= 3'h0;
            sd_reg      <= 1'b1;
            clk_err_reg <= 1'b0;
        end else if (ce) begin
            latched_reg <= latched_next;
            sd_reg      <= sd_next;
            clk_err_reg <= clk_err_next;
        end
    end

    assign flags      = {clk_err_reg, latched_reg};
    // clock error stops output but resumes by itself
    assign fault_hold = clk_err_reg | (|latched_reg);

    // ========================================================
    // trip scaling, percent of full level
    always_comb begin
        unique case (trip_level)
            2'h0: trip_percent = 8'h64;
            2'h1: trip_percent = 8'h4b;
            2'h2: trip_percent = 8'h32;
            2'h3: trip_percent = 8'h19;
        endcase
    end

endmodule : acf_fault_latch

// File: rtl/acf_regs.sv
/*
 * acf_regs: right volume, analog control and fault configuration /
 * status registers behind the control port, with their decodes.
 * assumes: a control-port engine outside presents a byte address,
 * write strobe and data each REF_CLK cycle; reads are combinational.
 */
`timescale 1ns/1ps

module acf_regs
    import acf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              REF_CLK,
    input  wire logic              RESETN,
    input  wire logic              CE,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic              WR_EN,
    input  wire logic [7:0]        WR_DATA,
    output logic      [7:0]        RD_DATA,
    output logic                   ADDR_HIT,
    input  wire logic              RATE_SPEED_SELECT,
    input  wire logic              SPEAKER_SHUTDOWN_N,
    input  wire logic              CLOCK_ERROR_DET,
    input  wire logic              OVERCURRENT_DET,
    input  wire logic              DC_OFFSET_DET,
    input  wire logic              OVERTEMP_DET,
    output logic      [7:0]        RIGHT_VOLUME_CODE,
    output logic                   RIGHT_MUTE,
    output logic      [8:0]        RIGHT_ATTEN_HALF_DB,
    output logic                   PARALLEL_MONO_MODE,
    output logic                   MONO_SOURCE_LEFT,
    output logic      [2:0]        OUTPUT_MODE,
    output logic      [5:0]        SWITCH_MULT_HALF,
    output logic      [7:0]        ANALOG_GAIN_CENTI_DBV,
    output logic                   GAIN_CODE_INVALID,
    output logic      [1:0]        OVERCURRENT_TRIP_LEVEL,
    output logic      [7:0]        TRIP_PERCENT,
    output logic                   SPEAKER_ENABLE,
    output logic                   DOUBLE_SPEED
);

    // ========================================================
    // rate multiple decode, used for both speed modes
    function automatic logic [4:0] rate_mult(input logic [2:0] code);
        logic [4:0] m;
        m = 5'h0;
        unique case (code)
            3'h0: m = 5'h06;
            3'h1: m = 5'h08;
            3'h2: m = 5'h0a;
            3'h3: m = 5'h0c;
            3'h4: m = 5'h0e;
            3'h5: m = 5'h10;
            3'h6: m = 5'h14;
            3'h7: m = 5'h18;
        endcase
        return m;
    endfunction : rate_mult

    // ========================================================
    // register state
    logic [7:0] vol_reg;
    logic [7:0] vol_next;
    logic [7:0] ana_reg;
    logic [7:0] ana_next;
    logic [1:0] trip_reg;
    logic [1:0] trip_next;
    logic       speed_reg;
    logic       speed_next;
    logic [3:0] flags;
    logic       fault_hold;
    logic       wr;

    assign wr = WR_EN & (ADDR == ADDR_W'(ACF_OFF_RIGHT_VOL) |
                         ADDR == ADDR_W'(ACF_OFF_ANALOG_CTRL) |
                         ADDR == ADDR_W'(ACF_OFF_FAULT));

    always_comb begin
        vol_next   = vol_reg;
        ana_next   = ana_reg;
        trip_next  = trip_reg;
        speed_next = RATE_SPEED_SELECT;
        if (wr) begin
            if (ADDR == ADDR_W'(ACF_OFF_RIGHT_VOL)) begin
                vol_next = WR_DATA;
            end
            if (ADDR == ADDR_W'(ACF_OFF_ANALOG_CTRL)) begin
                // every bit stored as written, reserved bit too
                ana_next = WR_DATA;
            end
            if (ADDR == ADDR_W'(ACF_OFF_FAULT)) begin
                trip_next = WR_DATA[ACF_BIT_TRIP_HI:ACF_BIT_TRIP_LO];
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            vol_reg   <= ACF_RST_RIGHT_VOL;
            ana_reg   <= ACF_RST_ANALOG_CTRL;
            trip_reg  <= ACF_RST_TRIP_LEVEL;
            speed_reg <= 1'b0;
        end else if (CE) begin
            vol_reg   <= vol_next;
            ana_reg   <= ana_next;
            trip_reg  <= trip_next;
            speed_reg <= speed_next;
        end
    end

    // ========================================================
    // fault flags
    acf_fault_latch u_fault (
        .clk           (REF_CLK),
        .resetn        (RESETN),
        .ce            (CE),
        .shutdown_n    (SPEAKER_SHUTDOWN_N),
        .clk_err_raw   (CLOCK_ERROR_DET),
        .overcur_raw   (OVERCURRENT_DET),
        .dc_offset_raw (DC_OFFSET_DET),
        .overtemp_raw  (OVERTEMP_DET),
        .trip_level    (trip_reg),
        .flags         (flags),
        .trip_percent  (TRIP_PERCENT),
        .fault_hold    (fault_hold)
    );

    // ========================================================
    // read mux; reserved slot and unmapped read as zero
    always_comb begin
        RD_DATA  = 8'h00;
        ADDR_HIT = 1'b1;
        if (ADDR == ADDR_W'(ACF_OFF_RIGHT_VOL)) begin
            RD_DATA = vol_reg;
        end else if (ADDR == ADDR_W'(ACF_OFF_ANALOG_CTRL)) begin
            RD_DATA = ana_reg;
        end else if (ADDR == ADDR_W'(ACF_OFF_FAULT)) begin
            RD_DATA = {2'h0, trip_reg, flags};
        end else begin
            // 0x07 left dead: writes dropped, reads zero
            ADDR_HIT = 1'b0;
        end
    end

    // ========================================================
    // volume decode
    always_comb begin
        RIGHT_VOLUME_CODE = vol_reg;
        RIGHT_MUTE        = vol_reg < ACF_VOL_MUTE_FLOOR;
        // half-dB steps below +24 dB; 0x07 gives 248 steps = -100 dB
        RIGHT_ATTEN_HALF_DB = 9'(8'hff - vol_reg);
    end

    // ========================================================
    // analog control decode
    always_comb begin
        PARALLEL_MONO_MODE = ana_reg[ACF_BIT_MONO_MODE];
        MONO_SOURCE_LEFT   = ana_reg[ACF_BIT_MONO_SOURCE];
        if (!PARALLEL_MONO_MODE) begin
            OUTPUT_MODE = ACF_MODE_STEREO;
        end else if (MONO_SOURCE_LEFT) begin
            OUTPUT_MODE = ACF_MODE_MONO_L;
        end else begin
            OUTPUT_MODE = ACF_MODE_MONO_R;
        end
        DOUBLE_SPEED = speed_reg;
        // multiple in halves so double speed stays exact
        if (speed_reg) begin
            SWITCH_MULT_HALF = {1'b0, rate_mult(
                ana_reg[ACF_BIT_RATE_HI:ACF_BIT_RATE_LO])};
        end else begin
            SWITCH_MULT_HALF = {rate_mult(
                ana_reg[ACF_BIT_RATE_HI:ACF_BIT_RATE_LO]), 1'b0};
        end
        GAIN_CODE_INVALID = ana_reg[ACF_BIT_GAIN_HI:ACF_BIT_GAIN_LO]
                            == ACF_GAIN_RESERVED;
        unique case (ana_reg[ACF_BIT_GAIN_HI:ACF_BIT_GAIN_LO])
            2'h0: ANALOG_GAIN_CENTI_DBV = 8'hc0;
            2'h1: ANALOG_GAIN_CENTI_DBV = 8'he2;
            2'h2: ANALOG_GAIN_CENTI_DBV = 8'hfa;
            2'h3: ANALOG_GAIN_CENTI_DBV = 8'hc0;
        endcase
        OVERCURRENT_TRIP_LEVEL = trip_reg;
        // latched faults and clock errors silence the outputs
        SPEAKER_ENABLE = SPEAKER_SHUTDOWN_N & ~fault_hold;
    end

endmodule : acf_regs

// File: sim/acf_regs_chk.sv
/* acf_regs_chk: port assertions for the register bank.
   assumes: bound onto acf_regs, one clock, default address width. */
`timescale 1ns/1ps
module acf_regs_chk
    import acf_pkg::*;
(
    input wire logic       REF_CLK,
    input wire logic       RESETN,
    input wire logic       CE,
    input wire logic [7:0] ADDR,
    input wire logic       WR_EN,
    input wire logic [7:0] WR_DATA,
    input wire logic [7:0] RD_DATA,
    input wire logic       ADDR_HIT,
    input wire logic       OVERCURRENT_DET,
    input wire logic [7:0] RIGHT_VOLUME_CODE,
    input wire logic       RIGHT_MUTE,
    input wire logic [8:0] RIGHT_ATTEN_HALF_DB,
    input wire logic       PARALLEL_MONO_MODE,
    input wire logic       MONO_SOURCE_LEFT,
    input wire logic [2:0] OUTPUT_MODE,
    input wire logic [1:0] OVERCURRENT_TRIP_LEVEL,
    input wire logic [7:0] TRIP_PERCENT,
    input wire logic       SPEAKER_ENABLE
);
    // ==========================================================
    // assertions
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    mute_floor_a: assert property (
        RIGHT_MUTE == (RIGHT_VOLUME_CODE < 8'h07))
        else $error("mute disagrees with volume code");
    atten_step_a: assert property (
        RIGHT_ATTEN_HALF_DB == 9'h0ff - {1'b0, RIGHT_VOLUME_CODE})
        else $error("attenuation off the volume code");
    vol_write_a: assert property (
        CE && WR_EN && ADDR == 8'h05 |=> RIGHT_VOLUME_CODE == $past(WR_DATA))
        else $error("volume write not taken");
    mode_map_a: assert property (
        OUTPUT_MODE == (!PARALLEL_MONO_MODE ? ACF_MODE_STEREO :
        (MONO_SOURCE_LEFT ? ACF_MODE_MONO_L : ACF_MODE_MONO_R)))
        else $error("output mode decode wrong");
    trip_scale_a: assert property (
        TRIP_PERCENT == 8'h64 - 8'h19 * OVERCURRENT_TRIP_LEVEL)
        else $error("trip percent wrong");
    latch_set_a: assert property (
        CE && OVERCURRENT_DET |=> !SPEAKER_ENABLE)
        else $error("overcurrent did not stop the speaker");
    unmapped_read_a: assert property (
        !ADDR_HIT |-> RD_DATA == 8'h00)
        else $error("unmapped read not zero");
    fault_rsvd_a: assert property (
        ADDR == 8'h08 |-> RD_DATA[7:6] == 2'h0)
        else $error("fault reserved bits not zero");
    // reset itself is the cause here, so nothing disables it
    reset_val_a: assert property (disable iff (1'b0)
        !RESETN && CE |=> RIGHT_VOLUME_CODE == 8'hcf && !PARALLEL_MONO_MODE)
        else $error("reset values wrong");
endmodule : acf_regs_chk

bind acf_regs acf_regs_chk u_acf_regs_chk (.REF_CLK(REF_CLK),
    .RESETN(RESETN), .CE(CE), .ADDR(ADDR), .WR_EN(WR_EN),
    .WR_DATA(WR_DATA), .RD_DATA(RD_DATA), .ADDR_HIT(ADDR_HIT),
    .OVERCURRENT_DET(OVERCURRENT_DET), .RIGHT_MUTE(RIGHT_MUTE),
    .RIGHT_VOLUME_CODE(RIGHT_VOLUME_CODE), .OUTPUT_MODE(OUTPUT_MODE),
    .RIGHT_ATTEN_HALF_DB(RIGHT_ATTEN_HALF_DB), .TRIP_PERCENT(TRIP_PERCENT),
    .PARALLEL_MONO_MODE(PARALLEL_MONO_MODE), .SPEAKER_ENABLE(SPEAKER_ENABLE),
    .MONO_SOURCE_LEFT(MONO_SOURCE_LEFT),
    .OVERCURRENT_TRIP_LEVEL(OVERCURRENT_TRIP_LEVEL));

// File: sim/acf_host.sv
/* acf_host: control-port host model, byte writes and reads.
   assumes: tasks called by the bench one at a time. */
`timescale 1ns/1ps
module acf_host (
    input  wire logic       REF_CLK,
    input  wire logic [7:0] RD_DATA,
    output logic      [7:0] ADDR,
    output logic            WR_EN,
    output logic      [7:0] WR_DATA
);
    // ==========================================================
    // bus cycles
    initial begin
        ADDR = 8'h00;
        WR_EN = 1'b0;
        WR_DATA = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 8'h06) begin
            v[0] = 1'b1;
            if (v[3:2] == 2'h3) v[3:2] = 2'h2;
        end
        @(posedge REF_CLK);
        ADDR <= (a == 8'h07) ? 8'h09 : a;
        WR_EN <= 1'b1;
        WR_DATA <= v;
        @(posedge REF_CLK);
        WR_EN <= 1'b0;
        WR_DATA <= ~v; // released data no longer shows the byte
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        #1;
        d = RD_DATA;
    endtask : rd
endmodule : acf_host

// File: sim/tb_acf_regs.sv
/* tb_acf_regs: self-checking bench with an integer register model.
   assumes: acf_regs with default address width, checker bound. */
`timescale 1ns/1ps
module tb_acf_regs
    import acf_pkg::*;
;
    logic       REF_CLK, RESETN, CE, RATE_SPEED_SELECT, SPEAKER_SHUTDOWN_N;
    logic       CLOCK_ERROR_DET;
    logic [2:0] det; // overcurrent, dc offset, overtemp
    logic [7:0] r, d;
    wire  [7:0] ADDR, WR_DATA, RD_DATA, RIGHT_VOLUME_CODE, TRIP_PERCENT;
    wire  [7:0] ANALOG_GAIN_CENTI_DBV;
    wire  [8:0] RIGHT_ATTEN_HALF_DB;
    wire  [2:0] OUTPUT_MODE;
    wire  [5:0] SWITCH_MULT_HALF;
    wire  [1:0] OVERCURRENT_TRIP_LEVEL;
    wire        WR_EN, ADDR_HIT, RIGHT_MUTE, PARALLEL_MONO_MODE, DOUBLE_SPEED;
    wire        MONO_SOURCE_LEFT, GAIN_CODE_INVALID, SPEAKER_ENABLE;
    int         fails, n_compared, vol, ana, trip, spd, i, j;
    int         mult[8] = '{6, 8, 10, 12, 14, 16, 20, 24};
    int         gain[3] = '{192, 226, 250};
    int         vtab[8] = '{7, 6, 255, 0, 8, 207, 1, 128};

    acf_regs u_acf_regs (.REF_CLK(REF_CLK), .RESETN(RESETN), .CE(CE),
        .ADDR(ADDR), .WR_EN(WR_EN), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
        .ADDR_HIT(ADDR_HIT), .RATE_SPEED_SELECT(RATE_SPEED_SELECT),
        .SPEAKER_SHUTDOWN_N(SPEAKER_SHUTDOWN_N),
        .CLOCK_ERROR_DET(CLOCK_ERROR_DET), .OVERCURRENT_DET(det[2]),
        .DC_OFFSET_DET(det[1]), .OVERTEMP_DET(det[0]),
        .RIGHT_VOLUME_CODE(RIGHT_VOLUME_CODE), .RIGHT_MUTE(RIGHT_MUTE),
        .RIGHT_ATTEN_HALF_DB(RIGHT_ATTEN_HALF_DB), .OUTPUT_MODE(OUTPUT_MODE),
        .PARALLEL_MONO_MODE(PARALLEL_MONO_MODE), .DOUBLE_SPEED(DOUBLE_SPEED),
        .MONO_SOURCE_LEFT(MONO_SOURCE_LEFT), .TRIP_PERCENT(TRIP_PERCENT),
        .SWITCH_MULT_HALF(SWITCH_MULT_HALF), .SPEAKER_ENABLE(SPEAKER_ENABLE),
        .ANALOG_GAIN_CENTI_DBV(ANALOG_GAIN_CENTI_DBV),
        .GAIN_CODE_INVALID(GAIN_CODE_INVALID),
        .OVERCURRENT_TRIP_LEVEL(OVERCURRENT_TRIP_LEVEL));
    acf_host u_acf_host (.REF_CLK(REF_CLK), .RD_DATA(RD_DATA), .ADDR(ADDR),
        .WR_EN(WR_EN), .WR_DATA(WR_DATA));

    // ==========================================================
    // compare and report
    task automatic chk(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input int e);
        logic [7:0] v;
        u_acf_host.rd(a, v);
        chk("rd_data", 9'(e), {1'b0, v});
    endtask : rdc
    task automatic check_all;
        rdc(ACF_OFF_RIGHT_VOL, vol);
        rdc(ACF_OFF_ANALOG_CTRL, ana);
        rdc(ACF_OFF_FAULT, trip << 4);
        chk("mute", vol < 7, RIGHT_MUTE);
        chk("atten", 255 - vol, RIGHT_ATTEN_HALF_DB);
        chk("mode", ana[7] ? (ana[1] ? 4 : 2) : 1, OUTPUT_MODE);
        chk("src", ana[1], MONO_SOURCE_LEFT);
        chk("speed", spd, DOUBLE_SPEED);
        chk("mult", mult[ana[6:4]] * (2 - spd), SWITCH_MULT_HALF);
        chk("gain", gain[ana[3:2]], ANALOG_GAIN_CENTI_DBV);
        chk("trip", 100 - 25 * trip, TRIP_PERCENT);
        chk("vol_code", vol, RIGHT_VOLUME_CODE);
        chk("mono", ana[7], PARALLEL_MONO_MODE);
        chk("gain_bad", 0, GAIN_CODE_INVALID);
        chk("trip_lvl", trip, OVERCURRENT_TRIP_LEVEL);
        chk("hit", 1, ADDR_HIT);
    endtask : check_all
    task automatic close_out;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // ==========================================================
    // clock, watchdog, sequence
    initial begin
        REF_CLK = 1'b0;
        forever #2 REF_CLK = ~REF_CLK;
    end
    initial begin
        #200000;
        fails++;
        close_out();
    end
    initial begin
        {RESETN, RATE_SPEED_SELECT, CLOCK_ERROR_DET, det} = 6'h00;
        {CE, SPEAKER_SHUTDOWN_N} = 2'h3;
        {fails, n_compared, spd} = '0;
        {vol, ana, trip} = {32'hcf, 32'h51, 32'h0};
        void'($urandom(82));
        repeat (10) @(posedge REF_CLK);
        RESETN <= 1'b1;
        check_all();
        for (i = 0; i < 16; i++) begin
            r = 8'($urandom % 3);
            d = 8'($urandom);
            if (r == 1) begin
                d[0] = 1'b1;
                d[3:2] = 2'(d[3:2] % 3);
            end
            u_acf_host.wr(8'h05 + r + 8'(r == 2), d);
            if (r == 0) vol = d;
            if (r == 1) ana = d;
            if (r == 2) trip = d[5:4];
            check_all();
        end
        // every rate, mode and trip code and the three non-reserved gain codes, at both speeds
        for (j = 0; j < 2; j++) begin
            RATE_SPEED_SELECT <= j[0];
            spd = j;
            for (i = 0; i < 8; i++) begin
                vol = vtab[i];
                ana = (i & 1) << 7 | i << 4 | (i % 3) << 2 | (i & 2) | 1;
                trip = i % 4;
                u_acf_host.wr(ACF_OFF_RIGHT_VOL, 8'(vol));
                u_acf_host.wr(ACF_OFF_ANALOG_CTRL, 8'(ana));
                u_acf_host.wr(ACF_OFF_FAULT, 8'(trip << 4) | 8'hcf);
                check_all();
            end
        end
        for (i = 0; i < 3; i++) begin
            @(posedge REF_CLK);
            det <= 3'(1 << i);
            @(posedge REF_CLK);
            det <= 3'h0;
            repeat (3) @(posedge REF_CLK);
            rdc(ACF_OFF_FAULT, trip << 4 | 1 << i);
            chk("spk_en", 0, SPEAKER_ENABLE);
            SPEAKER_SHUTDOWN_N <= 1'b0;
            repeat (2) @(posedge REF_CLK);
            rdc(ACF_OFF_FAULT, trip << 4);
            SPEAKER_SHUTDOWN_N <= 1'b1;
            repeat (2) @(posedge REF_CLK);
            chk("spk_en", 1, SPEAKER_ENABLE);
        end
        CLOCK_ERROR_DET <= 1'b1;
        rdc(ACF_OFF_FAULT, trip << 4 | 8);
        CLOCK_ERROR_DET <= 1'b0;
        @(posedge REF_CLK);
        rdc(ACF_OFF_FAULT, trip << 4);
        CE <= 1'b0;
        u_acf_host.wr(ACF_OFF_RIGHT_VOL, 8'(~vol));
        rdc(ACF_OFF_RIGHT_VOL, vol);
        CE <= 1'b1;
        rdc(8'h09, 0);
        chk("hit", 0, ADDR_HIT);
        RESETN <= 1'b0;
        @(posedge REF_CLK);
        RESETN <= 1'b1;
        rdc(ACF_OFF_ANALOG_CTRL, 8'h51);
        {vol, ana, trip} = {32'hcf, 32'h51, 32'h0};
        check_all();
        close_out();
    end
endmodule : tb_acf_regs
